// ### logic/csk_deb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface csk_deb_if;
    logic       sample_valid;
    logic [3:0] sample_code;
    logic [3:0] accepted_code;
    logic       change_pulse;

    modport seq (
        output sample_valid,
        output sample_code,
        input  accepted_code,
        input  change_pulse
    );
    modport deb (
        input  sample_valid,
        input  sample_code,
        output accepted_code,
        output change_pulse
    );
endinterface
`default_nettype wire

// ### logic/csk_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module csk_debounce (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // key samples in, accepted code out
    csk_deb_if.deb    deb
);

    logic [3:0]                   cand_r;
    logic [3:0]                   old_r;
    logic [csk_pkg::DEB_CNT_W-1:0] cnt_r;
    logic                         chg_r;

    wire same_w    = (deb.sample_code == cand_r);
    wire stable_w  = (cnt_r == csk_pkg::DEB_CNT_W'(csk_pkg::DEB_TICKS - 1));
    wire accept_w  = deb.sample_valid && same_w && stable_w && (cand_r != old_r);

    assign deb.accepted_code = old_r;
    assign deb.change_pulse  = chg_r;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cand_r <= csk_pkg::NO_KEY_CODE;
            old_r  <= csk_pkg::NO_KEY_CODE;
            cnt_r  <= '0;
            chg_r  <= 1'b0;
        end else begin
            chg_r <= accept_w;
            if (deb.sample_valid) begin
                if (!same_w) begin
                    // differing sample restarts the count
                    cand_r <= deb.sample_code; // R18
                    cnt_r  <= '0;
                end else if (!stable_w) begin
                    cnt_r <= cnt_r + 1'b1; // R14
                end
            end
            if (accept_w) begin
                old_r <= cand_r; // R15
            end
        end
    end

endmodule
`default_nettype wire

// ### logic/csk_pkg.sv
`default_nettype none
package csk_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int CONV_TIME_NS    = 15200;
    localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W      = 11;
    localparam int TICK_TIME_NS    = 1950000;
    localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W      = 18;
    localparam int CHATTER_TIME_NS = 10000000;
    localparam int DEB_TICKS       = CHATTER_TIME_NS / TICK_TIME_NS + 1;
    localparam int DEB_CNT_W       = 3;

    // search
    localparam int         SEARCH_STEPS = 4;
    localparam logic [3:0] NO_KEY_CODE  = 4'h8;

    // register offsets
    localparam logic [7:0] ADDR_CMP_MODE  = 8'h00;
    localparam logic [7:0] ADDR_PORT_MODE = 8'h04;
    localparam logic [7:0] ADDR_CMP_RES   = 8'h08;
    localparam logic [7:0] ADDR_KEY_CTRL  = 8'h0C;
    localparam logic [7:0] ADDR_KEY_STAT  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h1C;

    // comparator mode fields
    localparam int         MODE_INT_REF_BIT = 7;
    localparam logic [7:0] MODE_RST         = 8'hC0;

    // port mode: 1 = digital, 0 = analog
    localparam logic [3:0] PORT_MODE_RST = 4'hF;

    // key control fields
    localparam int         KCTL_SCAN_BIT = 0;
    localparam int         KCTL_ALT_BIT  = 1;
    localparam int         KCTL_CH_LSB   = 4;
    localparam logic [5:0] KCTL_RST      = 6'h00;

    // interrupt bits
    localparam int IRQ_KEY_BIT  = 0;
    localparam int IRQ_CONV_BIT = 1;
    localparam int IRQ_W        = 2;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_SW_CONV  = 2'b01,
        ST_KEY_CONV = 2'b10
    } csk_state_t;

endpackage
`default_nettype wire

// ### logic/csk_top.sv
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// [R01] sixteen-level internal reference from mode code
// [R02] reference internal or external fourth pin
// [R03] capture comparator outcome into result register
// [R04] result 1 when input above reference
// [R05] port mode zero makes pins analog
// [R06] mode upper nibble 0CH selects internal reference; the code selects it whenever mode bit 7 is set
// [R07] wait conversion time before sampling result
// [R08] exactly four comparisons per search
// [R09] first result in bit 3, downward
// [R10] default search codes 0 to 0EH
// [R11] alternative search codes 1 to 0FH
// [R12] key code is result plus one, shifted
// [R13] no key reports code eight
// [R14] tick-paced sampling tolerating 10 ms chatter
// [R15] sticky flag on accepted key change
// [R16] 1.95 ms tick starts one search
// [R17] set trial bit, compare, keep or clear
// [R18] accept after stable ticks, mismatch restarts
module csk_top #(
    parameter int TICK_CYCLES = csk_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // comparator front end
    input  wire logic [3:0] comparator_channel_input_i,
    output logic      [3:0] ref_code_o,
    output logic            external_reference_pin_sel_o,
    output logic            comparator_active_o,
    output logic      [3:0] analog_input_en_o,
    // key and interrupt
    output logic      [3:0] key_code_o,
    output logic            irq_o
);

    csk_deb_if deb_bus ();

    csk_pkg::csk_state_t state_r;
    csk_pkg::csk_state_t state_nxt;

    logic [7:0]                    comparator_mode_reg_r;
    logic [3:0]                    analog_port_mode_reg_r;
    logic [3:0]                    compare_result_reg_r;
    logic [5:0]                    key_ctrl_r;
    logic [csk_pkg::IRQ_W-1:0]     irq_stat_r;
    logic [csk_pkg::IRQ_W-1:0]     irq_en_r;
    logic [7:0]                    rdata_r;
    logic [3:0]                    bit_sequential_carrier_r;
    logic [3:0]                    search_result_r;
    logic [1:0]                    bit_idx_r;
    logic [3:0]                    ref_code_r;
    logic [csk_pkg::CONV_CNT_W-1:0] conv_cnt_r;
    logic [csk_pkg::TICK_CNT_W-1:0] tick_cnt_r;
    logic                          tick_pend_r;
    logic                          sample_valid_r;
    logic [3:0]                    sample_code_r;

    // register decode
    wire wr_mode_w    = reg_wr_i && (reg_addr_i == csk_pkg::ADDR_CMP_MODE);
    wire wr_port_w    = reg_wr_i && (reg_addr_i == csk_pkg::ADDR_PORT_MODE);
    wire wr_kctl_w    = reg_wr_i && (reg_addr_i == csk_pkg::ADDR_KEY_CTRL);
    wire wr_irq_clr_w = reg_wr_i && (reg_addr_i == csk_pkg::ADDR_IRQ_CLR);
    wire wr_irq_en_w  = reg_wr_i && (reg_addr_i == csk_pkg::ADDR_IRQ_EN);

    wire       scan_en_w = key_ctrl_r[csk_pkg::KCTL_SCAN_BIT];
    wire       alt_var_w = key_ctrl_r[csk_pkg::KCTL_ALT_BIT];
    wire [1:0] key_ch_w  = key_ctrl_r[csk_pkg::KCTL_CH_LSB +: 2];
    wire       int_ref_w = comparator_mode_reg_r[csk_pkg::MODE_INT_REF_BIT];

    // analog pins compare, digital pins read as low
    wire [3:0] cmp_now_w = comparator_channel_input_i & ~analog_port_mode_reg_r; // R04 R05
    wire       key_bit_w = cmp_now_w[key_ch_w];

    // interval tick
    wire tick_w = scan_en_w
               && (tick_cnt_r == csk_pkg::TICK_CNT_W'(TICK_CYCLES - 1)); // R16

    wire conv_done_w = (state_r != csk_pkg::ST_IDLE)
                    && (conv_cnt_r == csk_pkg::CONV_CNT_W'(csk_pkg::CONV_CYCLES - 1)); // R07

    wire start_key_w = (state_r == csk_pkg::ST_IDLE) && !wr_mode_w
                    && (tick_w || tick_pend_r) && scan_en_w;

    // trial code for current step
    wire [3:0] trial_w = bit_sequential_carrier_r | (4'h1 << bit_idx_r); // R17
    wire [3:0] trial_first_w = 4'h8;
    wire [3:0] key_ref_first_w = alt_var_w ? trial_first_w : trial_first_w - 4'h1;
    wire [3:0] key_ref_w = alt_var_w ? trial_w : trial_w - 4'h1; // R10 R11

    // finished carrier at last step
    wire [3:0] final_bsc_w = (bit_sequential_carrier_r & ~4'h1) | {3'h0, key_bit_w};
    wire [4:0] key_sum_w   = {1'b0, final_bsc_w} + 5'h01; // R12
    wire [3:0] key_calc_w  = key_sum_w[4:1]; // R13

    wire [csk_pkg::IRQ_W-1:0] irq_set_w = {
        conv_done_w && (state_r == csk_pkg::ST_SW_CONV),
        deb_bus.change_pulse
    };

    // read mux
    logic [7:0] rd_mux_w;
    always_comb begin
        rd_mux_w = 8'h00;
        case (reg_addr_i)
            csk_pkg::ADDR_CMP_MODE:  rd_mux_w = comparator_mode_reg_r;
            csk_pkg::ADDR_PORT_MODE: rd_mux_w = {4'h0, analog_port_mode_reg_r};
            csk_pkg::ADDR_CMP_RES:   rd_mux_w = {4'h0, compare_result_reg_r};
            csk_pkg::ADDR_KEY_CTRL:  rd_mux_w = {2'h0, key_ctrl_r};
            csk_pkg::ADDR_KEY_STAT:  rd_mux_w = {search_result_r, deb_bus.accepted_code};
            csk_pkg::ADDR_IRQ_STAT:  rd_mux_w = {6'h00, irq_stat_r};
            csk_pkg::ADDR_IRQ_EN:    rd_mux_w = {6'h00, irq_en_r};
            default:                 rd_mux_w = 8'h00;
        endcase
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            csk_pkg::ST_IDLE: begin
                if (wr_mode_w) begin
                    state_nxt = csk_pkg::ST_SW_CONV;
                end else if (start_key_w) begin
                    state_nxt = csk_pkg::ST_KEY_CONV;
                end
            end
            csk_pkg::ST_SW_CONV: begin
                if (conv_done_w) begin
                    state_nxt = csk_pkg::ST_IDLE;
                end
            end
            csk_pkg::ST_KEY_CONV: begin
                if (conv_done_w && (bit_idx_r == 2'd0)) begin
                    state_nxt = csk_pkg::ST_IDLE; // R08
                end
            end
            default: state_nxt = csk_pkg::ST_IDLE;
        endcase
    end

    assign deb_bus.sample_valid = sample_valid_r;
    assign deb_bus.sample_code  = sample_code_r;

    csk_debounce u_debounce (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .deb       (deb_bus)
    );

    assign reg_rdata_o                  = rdata_r;
    assign ref_code_o                   = ref_code_r; // R01
    assign external_reference_pin_sel_o = !int_ref_w; // R02 R06
    assign comparator_active_o          = (state_r != csk_pkg::ST_IDLE);
    assign analog_input_en_o            = ~analog_port_mode_reg_r;
    assign key_code_o                   = deb_bus.accepted_code;
    assign irq_o                        = |(irq_stat_r & irq_en_r);

    // software registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            comparator_mode_reg_r  <= csk_pkg::MODE_RST;
            analog_port_mode_reg_r <= csk_pkg::PORT_MODE_RST;
            key_ctrl_r             <= csk_pkg::KCTL_RST;
            irq_en_r               <= '0;
            irq_stat_r             <= '0;
            rdata_r                <= 8'h00;
        end else begin
            if (wr_mode_w) begin
                comparator_mode_reg_r <= reg_wdata_i;
            end
            if (wr_port_w) begin
                analog_port_mode_reg_r <= reg_wdata_i[3:0]; // R05
            end
            if (wr_kctl_w) begin
                key_ctrl_r <= reg_wdata_i[5:0];
            end
            if (wr_irq_en_w) begin
                irq_en_r <= reg_wdata_i[csk_pkg::IRQ_W-1:0];
            end
            // set wins over clear
            irq_stat_r <= (irq_stat_r & ~(wr_irq_clr_w ? reg_wdata_i[csk_pkg::IRQ_W-1:0]
                                                       : '0)) | irq_set_w; // R15
            rdata_r <= reg_rd_i ? rd_mux_w : 8'h00;
        end
    end

    // interval timer
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tick_cnt_r  <= '0;
            tick_pend_r <= 1'b0;
        end else begin
            if (!scan_en_w || tick_w) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
            end
            if (start_key_w || !scan_en_w) begin
                tick_pend_r <= 1'b0;
            end else if (tick_w) begin
                tick_pend_r <= 1'b1; // R16
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r                  <= csk_pkg::ST_IDLE;
            conv_cnt_r               <= '0;
            bit_idx_r                <= 2'd3;
            bit_sequential_carrier_r <= 4'h0;
            ref_code_r               <= 4'h0;
            compare_result_reg_r     <= 4'h0;
            search_result_r          <= csk_pkg::NO_KEY_CODE;
            sample_valid_r           <= 1'b0;
            sample_code_r            <= csk_pkg::NO_KEY_CODE;
        end else begin
            state_r        <= state_nxt;
            sample_valid_r <= 1'b0;
            if (state_r == csk_pkg::ST_IDLE || conv_done_w) begin
                conv_cnt_r <= '0;
            end else begin
                conv_cnt_r <= conv_cnt_r + 1'b1;
            end
            if (conv_done_w) begin
                compare_result_reg_r <= cmp_now_w; // R03
            end
            case (state_r)
                csk_pkg::ST_IDLE: begin
                    if (wr_mode_w) begin
                        ref_code_r <= reg_wdata_i[3:0]; // R01
                    end else if (start_key_w) begin
                        bit_idx_r                <= 2'd3;
                        bit_sequential_carrier_r <= 4'h0;
                        ref_code_r               <= key_ref_first_w; // R17
                    end
                end
                csk_pkg::ST_KEY_CONV: begin
                    if (conv_done_w) begin
                        // keep or clear trial bit
                        bit_sequential_carrier_r[bit_idx_r] <= key_bit_w; // R09 R17
                        if (bit_idx_r == 2'd0) begin
                            search_result_r <= final_bsc_w;
                            sample_code_r   <= key_calc_w; // R12
                            sample_valid_r  <= 1'b1; // R14
                        end else begin
                            bit_idx_r  <= bit_idx_r - 2'd1; // R08
                            ref_code_r <= alt_var_w
                                ? (({bit_sequential_carrier_r[3:1], 1'b0}
                                    & ~(4'h1 << bit_idx_r))
                                   | ({3'h0, key_bit_w} << bit_idx_r)
                                   | (4'h1 << (bit_idx_r - 2'd1)))
                                : ((({bit_sequential_carrier_r[3:1], 1'b0}
                                    & ~(4'h1 << bit_idx_r))
                                   | ({3'h0, key_bit_w} << bit_idx_r)
                                   | (4'h1 << (bit_idx_r - 2'd1))) - 4'h1); // R10 R11
                        end
                    end else begin
                        ref_code_r <= key_ref_w;
                    end
                end
                default: begin
                    ref_code_r <= ref_code_r;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### test/csk_ladder_model.sv
`timescale 1ns/10ps
`default_nettype none
module csk_ladder_model (
    // reference selection from the block
    input  wire logic [3:0]      ref_code_i,
    input  wire logic            ext_ref_sel_i,
    // ladder level per channel in 1/32 supply steps
    input  wire logic [3:0][5:0] level_i,
    // comparator outcome per channel
    output logic      [3:0]      cmp_o
);
    logic [5:0] thr;

    // internal level is (2*code+1)/32, else the fourth pin
    assign thr = ext_ref_sel_i ? level_i[3] : {1'b0, ref_code_i, 1'b1};

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp_o[i] = level_i[i] > thr;
        end
    end
endmodule
`default_nettype wire

// ### test/csk_props.sv
`timescale 1ns/10ps
`default_nettype none
module csk_props #(
    parameter int TICK_CYCLES = csk_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // comparator front end
    input wire logic [3:0] comparator_channel_input_i,
    input wire logic [3:0] ref_code_o,
    input wire logic       external_reference_pin_sel_o,
    input wire logic       comparator_active_o,
    input wire logic [3:0] analog_input_en_o,
    // key and interrupt
    input wire logic [3:0] key_code_o,
    input wire logic       irq_o
);
    localparam int MAX_ACT = 4 * csk_pkg::CONV_CYCLES + 4;
    logic [15:0] act_cnt_r;

    // length of the current busy stretch
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !comparator_active_o) begin
            act_cnt_r <= 16'h0000;
        end else begin
            act_cnt_r <= act_cnt_r + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_mode_write;
        reg_wr_i && reg_addr_i == csk_pkg::ADDR_CMP_MODE;
    endsequence
    sequence s_search_start;
        $rose(comparator_active_o) && !$past(reg_wr_i);
    endsequence

    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
    a_conv_hold: assert property ($rose(comparator_active_o) |=> comparator_active_o[*8])
        else $error("conversion ended too early");
    a_act_bound: assert property (act_cnt_r <= 16'(MAX_ACT))
        else $error("search runs longer than four steps");
    a_sw_start: assert property (!comparator_active_o ##0 s_mode_write
        |=> comparator_active_o && ref_code_o == $past(reg_wdata_i[3:0]))
        else $error("software comparison did not start at its code");
    a_trial_first: assert property (s_search_start |-> ref_code_o inside {4'h7, 4'h8})
        else $error("search did not start at the top trial bit");
    a_ext_sel: assert property (s_mode_write
        |=> external_reference_pin_sel_o == !$past(reg_wdata_i[7]))
        else $error("reference source select wrong");
    a_port_en: assert property (reg_wr_i && reg_addr_i == csk_pkg::ADDR_PORT_MODE
        |=> analog_input_en_o == ~$past(reg_wdata_i[3:0]))
        else $error("analog enable does not follow port mode");
    a_key_range: assert property (key_code_o <= 4'h8)
        else $error("key code above eight");
    a_key_reset: assert property ($fell(reset_i) |-> key_code_o == 4'h8 && !irq_o)
        else $error("key code after reset not eight");
    a_key_quiet: assert property ($changed(key_code_o) |-> !comparator_active_o)
        else $error("key code changed during a search");
endmodule
`default_nettype wire

// ### test/tb_comparator_sar_key_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t got %0h expected %0h", $time, got, exp); end end
module tb_comparator_sar_key_decoder;
    localparam int TICK  = 8000;
    localparam int LIMIT = 95000;
    logic            sys_clk_i;
    logic            reset_i;
    logic [7:0]      reg_addr_i;
    logic [7:0]      reg_wdata_i;
    logic            reg_wr_i;
    logic            reg_rd_i;
    logic [7:0]      reg_rdata_o;
    logic [3:0]      cmp;
    logic [3:0]      ref_code_o;
    logic            ext_sel;
    logic            comparator_active_o;
    logic [3:0]      analog_input_en_o;
    logic [3:0]      key_code_o;
    logic            irq_o;
    logic [3:0][5:0] level;
    int              miscompares;
    int              compares;
    int              cycles;

    csk_top #(.TICK_CYCLES(TICK)) csk_top_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .comparator_channel_input_i(cmp),
        .ref_code_o(ref_code_o), .external_reference_pin_sel_o(ext_sel),
        .comparator_active_o(comparator_active_o), .analog_input_en_o(analog_input_en_o),
        .key_code_o(key_code_o), .irq_o(irq_o));
    csk_ladder_model csk_ladder_model_i (.ref_code_i(ref_code_o), .ext_ref_sel_i(ext_sel),
        .level_i(level), .cmp_o(cmp));

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    task complete_run();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // single comparison, returns busy length and result register
    task automatic conv(input logic [7:0] m, output int n, output logic [7:0] d);
        wr(csk_pkg::ADDR_CMP_MODE, m);
        n = 0;
        #1;
        while (comparator_active_o === 1'b1 && n < 3000) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        `CHK(n, csk_pkg::CONV_CYCLES)
        rd(csk_pkg::ADDR_CMP_RES, d);
    endtask

    task automatic t_reset_values();
        logic [7:0] d;
        `CHK(key_code_o, csk_pkg::NO_KEY_CODE)
        `CHK(analog_input_en_o, 4'h0)
        rd(csk_pkg::ADDR_CMP_MODE, d);
        `CHK(d, 8'hC0)
        rd(csk_pkg::ADDR_PORT_MODE, d);
        `CHK(d, 8'h0F)
        rd(csk_pkg::ADDR_KEY_STAT, d);
        `CHK(d[3:0], 4'h8)
        rd(8'h20, d);
        `CHK(d, 8'h00)
    endtask

    task automatic t_sw_conv();
        logic [7:0] d;
        int n;
        conv(8'h85, n, d);
        `CHK(d, 8'h00)
        wr(csk_pkg::ADDR_PORT_MODE, 8'h00);
        #1 `CHK(analog_input_en_o, 4'hF)
        wr(csk_pkg::ADDR_IRQ_EN, 8'h02);
        conv(8'h85, n, d);
        `CHK(d[3:0], 4'h9)
        `CHK(irq_o, 1'b1)
        wr(csk_pkg::ADDR_IRQ_CLR, 8'h02);
        repeat (2) @(posedge sys_clk_i);
        #1 `CHK(irq_o, 1'b0)
        conv(8'h05, n, d);
        `CHK(ext_sel, 1'b1)
        `CHK(d[3:0], 4'h1)
        conv(8'hC0, n, d);
        `CHK(d[3:0], 4'hF)
    endtask

    // alternative search on channel 2, trials recorded
    task automatic t_alt_search();
        logic [3:0] q[$];
        logic [7:0] d;
        int n;
        wr(csk_pkg::ADDR_KEY_CTRL, 8'h23);
        n = 0;
        while (comparator_active_o !== 1'b1 && n < TICK + 100) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        `CHK(n, TICK)
        q.push_back(ref_code_o);
        repeat (4 * csk_pkg::CONV_CYCLES + 8) begin
            @(posedge sys_clk_i);
            #1;
            if (comparator_active_o === 1'b1 && ref_code_o !== q[$]) begin
                q.push_back(ref_code_o);
            end
        end
        `CHK(q.size(), 4)
        `CHK({q[0], q[1], q[2], q[3]}, 16'h8465)
        rd(csk_pkg::ADDR_KEY_STAT, d);
        `CHK(d[7:4], 4'h4)
    endtask

    task automatic t_debounce();
        logic [7:0] d;
        int n;
        wr(csk_pkg::ADDR_KEY_CTRL, 8'h21);
        wr(csk_pkg::ADDR_IRQ_EN, 8'h01);
        repeat (4 * TICK) @(posedge sys_clk_i);
        #1 `CHK(key_code_o, 4'h8)
        n = 0;
        while (key_code_o !== 4'h3 && n < 4 * TICK) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        `CHK(key_code_o, 4'h3)
        `CHK(n > 2 * TICK, 1'b1)
        repeat (4) @(posedge sys_clk_i);
        #1 `CHK(irq_o, 1'b1)
        rd(csk_pkg::ADDR_IRQ_STAT, d);
        `CHK(d[0], 1'b1)
        rd(csk_pkg::ADDR_KEY_STAT, d);
        `CHK(d, 8'h53)
        wr(csk_pkg::ADDR_IRQ_CLR, 8'h01);
        repeat (2) @(posedge sys_clk_i);
        #1 `CHK(irq_o, 1'b0)
    endtask

    initial begin
        miscompares = 0;
        compares    = 0;
        cycles      = 0;
        reset_i     = 1'b1;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        level       = {6'd30, 6'd10, 6'd4, 6'd32};
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        t_reset_values();
        t_sw_conv();
        t_alt_search();
        t_debounce();
        complete_run();
    end
endmodule

bind csk_top csk_props #(.TICK_CYCLES(TICK_CYCLES)) csk_props_i (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .comparator_channel_input_i(comparator_channel_input_i), .ref_code_o(ref_code_o),
    .external_reference_pin_sel_o(external_reference_pin_sel_o),
    .comparator_active_o(comparator_active_o), .analog_input_en_o(analog_input_en_o),
    .key_code_o(key_code_o), .irq_o(irq_o));
`default_nettype wire
